// [shared/cp_xfer_defs.vh]
/*
  constants for the coprocessor transfer sequencer: handshake codes,
  request cycle types, instruction kinds and the undefined-trap fetch
  addresses. assumes it is included by bare name from the core files.
*/
`ifndef CP_XFER_DEFS_VH
`define CP_XFER_DEFS_VH

// handshake answers from the coprocessor
`define HS_ABSENT 2'h0
`define HS_WAIT 2'h1
`define HS_GO 2'h2
`define HS_LAST 2'h3

// request cycle types as {request_n, sequential}
`define CYC_N 2'h0
`define CYC_S 2'h1
`define CYC_I 2'h2
`define CYC_C 2'h3

// coprocessor instruction kinds
`define KIND_TO_CP 2'h0
`define KIND_FROM_CP 2'h1
`define KIND_DBL_TO_CP 2'h2
`define KIND_DBL_FROM_CP 2'h3

// undefined-instruction trap fetch sequence
`define TRAP_FIRST_ADDR 32'h0000_0004
`define TRAP_ADDR_STEP 32'h0000_0004
`define TRAP_LAST_STEP 2'h2

`endif

// [core/cp_trap_fetch.v]
/*
  undefined-instruction trap fetch stepper: three fetches, the first
  non-sequential, the rest sequential. gives next-cycle values so the
  top can register them. assumes one clock and a synchronous reset.
*/
`include "cp_xfer_defs.vh"

module cp_trap_fetch (
  // clock and reset
  input wire i_core_clk,
  input wire i_reset_n,
  // control
  input wire i_start,
  // next-cycle fetch values
  output reg o_valid_next,
  output reg [31:0] o_addr_next,
  output reg o_seq_next,
  output reg o_last_next
);

  reg active_reg; // a trap fetch cycle is being driven
  reg [1:0] step_reg; // which trap fetch is being driven
  reg [1:0] step_next;

  ////////////////////////////////////////////////////////////////////
  // address of a trap fetch step
  function [31:0] step_addr;
    input [1:0] step;
    begin
      step_addr = `TRAP_FIRST_ADDR + ({30'h0, step} * `TRAP_ADDR_STEP);
    end
  endfunction

  // next step: restart wins over a running sequence
  always @* begin
    o_valid_next = 1'b0;
    step_next = 2'h0;
    if (i_start) begin
      o_valid_next = 1'b1; // first fetch is the non-sequential one
    end else if (active_reg && (step_reg != `TRAP_LAST_STEP)) begin
      o_valid_next = 1'b1;
      step_next = step_reg + 2'h1;
    end
    o_addr_next = step_addr(step_next);
    o_seq_next = (step_next != 2'h0);
    o_last_next = o_valid_next && (step_next == `TRAP_LAST_STEP);
  end

  // step registers
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      active_reg <= 1'b0;
      step_reg <= 2'h0;
    end else begin
      active_reg <= o_valid_next;
      step_reg <= step_next;
    end
  end

endmodule // cp_trap_fetch

// [core/cp_data_phase.v]
/*
  data phase of coprocessor-type cycles: write data follows a write
  c-cycle by one cycle like a store, read data is captured one cycle
  after a read c-cycle like a load. assumes the source registers hold
  steady for the whole instruction.
*/
`include "cp_xfer_defs.vh"

module cp_data_phase (
  // clock and reset
  input wire i_core_clk,
  input wire i_reset_n,
  // address phase from the sequencer
  input wire i_c_cycle,
  input wire i_word2,
  input wire i_last_word,
  input wire i_write_dir,
  // data sources
  input wire [31:0] i_src_data,
  input wire [31:0] i_second_source_reg,
  input wire [31:0] i_read_data,
  // data phase results
  output reg [31:0] o_write_data,
  output reg o_write_data_oe,
  output reg [31:0] o_read_word1,
  output reg [31:0] o_read_word2,
  output reg o_read_done
);

  reg rd_pend_reg; // a read word is on the bus this cycle
  reg rd_word2_reg; // that word is the second one
  reg rd_last_reg; // that word ends the transfer

  ////////////////////////////////////////////////////////////////////
  // write data phase and read capture
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_write_data <= 32'h0000_0000;
      o_write_data_oe <= 1'b0;
      o_read_word1 <= 32'h0000_0000;
      o_read_word2 <= 32'h0000_0000;
      o_read_done <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_word2_reg <= 1'b0;
      rd_last_reg <= 1'b0;
    end else begin
      // first source then second source, one word per c-cycle
      o_write_data_oe <= i_c_cycle && i_write_dir; // [RULE2] [RULE5]
      if (i_c_cycle && i_write_dir) begin
        o_write_data <= i_word2 ? i_second_source_reg : i_src_data; // [RULE5]
      end
      rd_pend_reg <= i_c_cycle && !i_write_dir; // [RULE4]
      rd_word2_reg <= i_word2;
      rd_last_reg <= i_last_word;
      // capture lands the cycle after the c-cycle, as a load would
      if (rd_pend_reg && !rd_word2_reg) begin
        o_read_word1 <= i_read_data; // [RULE3] [RULE4]
      end
      if (rd_pend_reg && rd_word2_reg) begin
        o_read_word2 <= i_read_data; // [RULE3]
      end
      o_read_done <= rd_pend_reg && rd_last_reg;
    end
  end

endmodule // cp_data_phase

// [core/cp_transfer_seq.v]
/*
  processor-side sequencer for coprocessor register transfers: single
  and double moves in both directions, absent coprocessor trap and
  condition-failed single cycles. assumes the issue stage offers one
  instruction at a time with its pc+3i fetch address, and that the
  coprocessor answers on the two handshake inputs each cycle.
*/
// What this block does
// [RULE1] single move out: one c-cycle after last
// [RULE2] write data as store, no data address
// [RULE3] double move in: go, last, two captures
// [RULE4] coprocessor words captured as load, no address
// [RULE5] double move out: first then second source
// [RULE6] interrupt abandons a busy-waiting instruction
// [RULE7] transfers only in the 32-bit state
// [RULE8] nobody accepts: trap fetches 0x4, 0x8, 0xC
// [RULE9] idle coprocessor answers absent on both
// [RULE10] failed condition: no execute, one cycle
// [RULE11] wait gives idle cycles, fetch address held
// [RULE12] pass high, late cancel low throughout transfer
// [RULE13] wait then absent: pass drops, trap follows
// [RULE14] failed condition: sequential fetch, data idle
// [RULE15] wait, go, last: c-cycles after go
// [RULE16] decode answer first cycle, execute answer after
`include "cp_xfer_defs.vh"

module cp_transfer_seq (
  // clock and reset
  input wire i_core_clk,
  input wire i_reset_n,
  // instruction issue
  input wire i_fetched_word_valid,
  input wire [1:0] i_fetched_word_kind,
  input wire i_cond_pass,
  input wire i_compressed_state,
  input wire [31:0] i_fetch_pc,
  input wire i_irq_pending,
  // core register sources
  input wire [31:0] i_src_data,
  input wire [31:0] i_second_source_reg,
  // coprocessor handshake and read bus
  input wire [1:0] i_decode_handshake,
  input wire [1:0] i_execute_handshake,
  input wire [31:0] i_read_data,
  // issue answer
  output reg o_ready,
  output reg o_undef_trap,
  output reg o_abandoned,
  // instruction interface
  output reg [31:0] o_fetch_address,
  output reg o_fetched_word_request_n,
  output reg o_fetched_word_sequential,
  // data interface
  output reg o_data_request_n,
  output reg o_data_sequential,
  output reg [31:0] o_data_address_bus,
  output reg o_data_address_oe,
  output wire [31:0] o_write_data,
  output wire o_write_data_oe,
  output wire [31:0] o_read_word1,
  output wire [31:0] o_read_word2,
  output wire o_read_done,
  // coprocessor control
  output reg o_pass,
  output reg o_late_cancel_flag
);

  // states name the cycle being driven
  // no state for the c-cycle of a single move: it is always the last
  // one, so S_XLAST covers it and keeps the decode short
  localparam [2:0] S_IDLE = 3'h0; // nothing issued
  localparam [2:0] S_SKIP = 3'h1; // condition-failed single cycle
  localparam [2:0] S_WAIT = 3'h2; // coprocessor busy-waiting
  localparam [2:0] S_ABS = 3'h3; // absent in decode, trap next
  localparam [2:0] S_XFER1 = 3'h4; // first c-cycle of a double, and its stall cycles before last
  localparam [2:0] S_XLAST = 3'h5; // last c-cycle
  localparam [2:0] S_TRAP = 3'h6; // undefined trap fetches

  // sequencer state and next-cycle values
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [1:0] kind_reg; // kind of the instruction in flight
  reg [1:0] kind_next;
  reg [31:0] fetch_next;
  reg [1:0] icyc_next; // instruction cycle type
  reg [1:0] dcyc_next; // data cycle type
  reg pass_next;
  reg ready_next;
  reg undef_next;
  reg abandon_next;
  reg c_cycle_reg; // current cycle is a c-cycle
  reg c_cycle_next;
  reg word2_reg; // that c-cycle moves the second word
  reg word2_next;
  reg last_word_reg; // that c-cycle moves the final word
  reg last_word_next;
  reg trap_start; // trap fetch starts next cycle
  reg [1:0] resp; // handshake answer in force this cycle
  reg from_decode; // answer came from the decode handshake
  reg take_resp; // answer is to be acted on
  wire accept; // instruction taken at this edge
  wire dbl_kind; // in-flight kind moves two words
  // trap stepper outputs, values for the next cycle
  wire trap_valid_next;
  wire [31:0] trap_addr_next;
  wire trap_seq_next;
  wire trap_last_next;

  // a new instruction only enters when the previous one has ended
  assign accept = i_fetched_word_valid && o_ready;
  // kind_next so the decode cycle already knows the width of the move
  assign dbl_kind = (kind_next == `KIND_DBL_TO_CP) || (kind_next == `KIND_DBL_FROM_CP);

  ////////////////////////////////////////////////////////////////////
  // undefined trap fetch stepper
  cp_trap_fetch u_cp_trap_fetch (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_start(trap_start),
    .o_valid_next(trap_valid_next),
    .o_addr_next(trap_addr_next),
    .o_seq_next(trap_seq_next),
    .o_last_next(trap_last_next)
  );

  ////////////////////////////////////////////////////////////////////
  // data phase of coprocessor cycles
  cp_data_phase u_cp_data_phase (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_c_cycle(c_cycle_reg),
    .i_word2(word2_reg),
    .i_last_word(last_word_reg),
    .i_write_dir((kind_reg == `KIND_TO_CP) || (kind_reg == `KIND_DBL_TO_CP)),
    .i_src_data(i_src_data),
    .i_second_source_reg(i_second_source_reg),
    .i_read_data(i_read_data),
    .o_write_data(o_write_data),
    .o_write_data_oe(o_write_data_oe),
    .o_read_word1(o_read_word1),
    .o_read_word2(o_read_word2),
    .o_read_done(o_read_done)
  );

  ////////////////////////////////////////////////////////////////////
  // pick which handshake answer counts this cycle
  always @* begin
    resp = `HS_ABSENT;
    from_decode = 1'b0;
    take_resp = 1'b0;
    if (o_ready) begin
      // first cycle of an instruction looks at decode only
      from_decode = 1'b1; // [RULE16]
      resp = i_decode_handshake; // [RULE16]
      take_resp = accept && i_cond_pass && !i_compressed_state;
    // later cycles listen only while the coprocessor still owes an answer
    end else if ((state_reg == S_WAIT) || (state_reg == S_XFER1)) begin
      resp = i_execute_handshake; // [RULE16]
      take_resp = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // next cycle: state and every registered output value except the data address and late cancel
  always @* begin
    state_next = S_IDLE;
    kind_next = kind_reg;
    fetch_next = o_fetch_address; // idle cycles keep the address
    icyc_next = `CYC_I;
    dcyc_next = `CYC_I;
    pass_next = 1'b0;
    undef_next = 1'b0;
    abandon_next = 1'b0;
    c_cycle_next = 1'b0;
    word2_next = 1'b0;
    last_word_next = 1'b0;
    trap_start = 1'b0;
    // a new instruction; its handshake answer is handled further down
    if (o_ready && accept) begin
      kind_next = i_fetched_word_kind;
      fetch_next = i_fetch_pc;
      if (!i_cond_pass) begin
        // not executed: one sequential fetch, data idle
        state_next = S_SKIP; // [RULE10]
        icyc_next = `CYC_S; // [RULE14]
        dcyc_next = `CYC_I; // [RULE14]
      end else if (i_compressed_state) begin
        // no coprocessor path in the compressed state
        trap_start = 1'b1; // [RULE7]
      end
    end else if (state_reg == S_ABS) begin
      trap_start = 1'b1; // [RULE8]
    end else if (state_reg == S_WAIT && i_irq_pending) begin
      // interrupt wins over a stalled coprocessor
      abandon_next = 1'b1; // [RULE6]
    end else if (state_reg == S_TRAP && trap_valid_next) begin
      state_next = S_TRAP;
    end
    // act on the handshake answer in force
    // an interrupt in a wait cycle masks the answer of that same cycle
    if (take_resp && !(state_reg == S_WAIT && i_irq_pending)) begin
      pass_next = 1'b1; // [RULE12]
      case (resp)
        `HS_ABSENT: begin
          // absent in decode: one pass cycle first, then the trap
          if (from_decode) begin
            state_next = S_ABS; // [RULE8]
          end else begin
            // pass drops with the trap fetch that follows
            pass_next = 1'b0; // [RULE13]
            trap_start = 1'b1; // [RULE13]
          end
        end
        `HS_WAIT: begin
          // idle on both interfaces, fetch address held
          state_next = S_WAIT; // [RULE11]
          if (state_reg == S_XFER1) begin
            state_next = S_XFER1; // stall between go and last
          end
        end
        `HS_GO: begin
          // go on a double opens the first c-cycle; a second go closes it
          if (dbl_kind && state_reg != S_XFER1) begin
            state_next = S_XFER1; // [RULE15]
            dcyc_next = `CYC_C; // [RULE3] [RULE5]
            c_cycle_next = 1'b1;
          end else begin
            state_next = S_XLAST; // single kinds commit on go too
          end
        end
        default: begin
          state_next = S_XLAST; // [RULE1]
        end
      endcase
      if (state_next == S_XLAST) begin
        // final c-cycle and the return to sequential fetch
        icyc_next = `CYC_S; // [RULE1]
        dcyc_next = `CYC_C; // [RULE1] [RULE15]
        c_cycle_next = 1'b1;
        word2_next = (state_reg == S_XFER1); // [RULE3] [RULE5]
        last_word_next = 1'b1;
      end
    end
    // trap fetches override everything else
    // the stepper runs its three cycles on its own once started
    if (trap_valid_next) begin
      state_next = S_TRAP; // [RULE8]
      fetch_next = trap_addr_next; // [RULE8]
      icyc_next = trap_seq_next ? `CYC_S : `CYC_N; // [RULE8]
      dcyc_next = `CYC_I;
      pass_next = 1'b0; // [RULE8]
      undef_next = trap_start;
    end
    // ready while the next cycle ends what is in flight
    // a trap is ready only in its last fetch so the third fetch is not cut
    ready_next = (state_next == S_IDLE) || (state_next == S_SKIP) ||
                 (state_next == S_XLAST) || (state_next == S_TRAP && trap_last_next);
  end

  ////////////////////////////////////////////////////////////////////
  // registered outputs; data address never driven by these cycles
  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      // ready out of reset: the first edge after release may take one
      state_reg <= S_IDLE;
      kind_reg <= `KIND_TO_CP;
      o_ready <= 1'b1;
      o_undef_trap <= 1'b0;
      o_abandoned <= 1'b0;
      o_fetch_address <= 32'h0000_0000;
      o_fetched_word_request_n <= 1'b1;
      o_fetched_word_sequential <= 1'b0;
      o_data_request_n <= 1'b1;
      o_data_sequential <= 1'b0;
      o_data_address_bus <= 32'h0000_0000;
      o_data_address_oe <= 1'b0;
      o_pass <= 1'b0;
      o_late_cancel_flag <= 1'b0;
      c_cycle_reg <= 1'b0;
      word2_reg <= 1'b0;
      last_word_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      o_ready <= ready_next;
      o_undef_trap <= undef_next;
      o_abandoned <= abandon_next;
      o_fetch_address <= fetch_next; // [RULE11]
      o_fetched_word_request_n <= icyc_next[1];
      o_fetched_word_sequential <= icyc_next[0];
      o_data_request_n <= dcyc_next[1];
      o_data_sequential <= dcyc_next[0];
      // coprocessor cycles carry no address; the bus stays parked at zero
      o_data_address_bus <= 32'h0000_0000;
      o_data_address_oe <= 1'b0; // [RULE2] [RULE4]
      o_pass <= pass_next; // [RULE12]
      o_late_cancel_flag <= 1'b0; // [RULE12]
      c_cycle_reg <= c_cycle_next;
      word2_reg <= word2_next;
      last_word_reg <= last_word_next;
    end
  end

endmodule // cp_transfer_seq

// [test/cp_transfer_props.sv]
/* port checker for the transfer sequencer.
   assumes one clock and a synchronous active-low reset. */
`include "cp_xfer_defs.vh"
module cp_transfer_props (
  // clock and reset
  input logic i_core_clk,
  input logic i_reset_n,
  // issue side
  input logic i_fetched_word_valid,
  input logic [1:0] i_fetched_word_kind,
  input logic i_cond_pass,
  input logic i_compressed_state,
  input logic [31:0] i_fetch_pc,
  input logic i_irq_pending,
  input logic [1:0] i_decode_handshake,
  input logic [1:0] i_execute_handshake,
  // design outputs
  input logic o_ready,
  input logic o_undef_trap,
  input logic o_abandoned,
  input logic [31:0] o_fetch_address,
  input logic o_fetched_word_request_n,
  input logic o_fetched_word_sequential,
  input logic o_data_request_n,
  input logic o_data_sequential,
  input logic [31:0] o_data_address_bus,
  input logic o_data_address_oe,
  input logic o_write_data_oe,
  input logic o_read_done,
  input logic o_pass,
  input logic o_late_cancel_flag
);
  ////////////////////////////////////////
  // cycle types and the busy-wait state
  logic take;
  logic stall;
  logic [1:0] ic;
  logic [1:0] dc;
  assign take = i_fetched_word_valid && o_ready;
  assign ic = {o_fetched_word_request_n, o_fetched_word_sequential};
  assign dc = {o_data_request_n, o_data_sequential};
  assign stall = !o_ready && o_pass && ic == `CYC_I && dc == `CYC_I;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  a_no_data_addr:
    assert property (o_data_address_oe == 1'h0 && o_data_address_bus == 32'h0)
    else $error("data address driven");
  a_late_cancel_low:
    assert property (o_late_cancel_flag == 1'h0) else $error("late cancel raised");
  a_c_cycle_pass:
    assert property (dc == `CYC_C |-> o_pass) else $error("c-cycle without pass");
  a_write_after_c:
    assert property (o_write_data_oe |-> $past(dc) == `CYC_C) else $error("stray write data");
  a_trap_fetch_order:
    assert property (o_undef_trap |-> o_fetch_address == 32'h4 && ic == `CYC_N && !o_pass
      ##1 o_fetch_address == 32'h8 && ic == `CYC_S
      ##1 o_fetch_address == 32'hC && ic == `CYC_S && o_ready) else $error("trap fetch order");
  a_trap_data_idle:
    assert property (o_undef_trap |-> (dc == `CYC_I && !o_pass) [*3]) else $error("trap data");
  a_wait_stall_hold:
    assert property (stall && i_execute_handshake == `HS_WAIT && !i_irq_pending |=>
      ic == `CYC_I && dc == `CYC_I && o_pass && $stable(o_fetch_address))
    else $error("wait not held");
  a_absent_to_trap:
    assert property (stall && i_execute_handshake == `HS_ABSENT && !i_irq_pending
      |=> o_undef_trap) else $error("absent did not trap");
  a_irq_abandon:
    assert property (stall && i_execute_handshake == `HS_WAIT && i_irq_pending
      |=> o_abandoned && o_ready && !o_pass) else $error("wait not abandoned");
  a_skip_one_cycle:
    assert property (take && !i_cond_pass && !i_compressed_state |=> ic == `CYC_S
      && dc == `CYC_I && !o_pass && o_ready && o_fetch_address == $past(i_fetch_pc))
    else $error("failed condition not skipped");
  a_compressed_trap:
    assert property (take && i_compressed_state && i_cond_pass |=> o_undef_trap)
    else $error("compressed state transfer");
  a_decode_last:
    assert property (take && i_cond_pass && !i_compressed_state && !i_fetched_word_kind[1]
      && i_decode_handshake == `HS_LAST |=> ic == `CYC_S && dc == `CYC_C && o_pass)
    else $error("single transfer late");
  c_trap: cover property (o_undef_trap);
  c_abandon: cover property (o_abandoned);
  c_read_done: cover property (o_read_done);
endmodule // cp_transfer_props

// [test/cp_model.sv]
/* behavioural coprocessor following a script set by the bench.
   assumes it sees the core's ready and data cycle type each cycle. */
`include "cp_xfer_defs.vh"
module cp_model (
  // clock and core side
  input logic i_core_clk,
  input logic i_fetched_word_valid,
  input logic i_ready,
  input logic [1:0] i_data_cycle,
  // script: decode answer, wait count, final answer, read words
  input logic [1:0] i_dec,
  input logic [3:0] i_waits,
  input logic [1:0] i_fin,
  input logic [31:0] i_word1,
  input logic [31:0] i_word2,
  // handshake and read bus
  output logic [1:0] o_decode_handshake,
  output logic [1:0] o_execute_handshake,
  output logic [31:0] o_read_data
);
  ////////////////////////////////////////
  logic busy_reg = 1'b0; // handling an instruction
  logic [3:0] cyc_reg = 4'h0; // cycle number inside it
  logic word2_reg = 1'b0; // next c-cycle carries word two
  // decode answer only in the taking cycle
  assign o_decode_handshake = (i_fetched_word_valid && i_ready) ? i_dec : `HS_ABSENT;
  // execute answers follow the script, absent when not ours
  always_comb begin
    o_execute_handshake = `HS_ABSENT;
    if (busy_reg && !i_ready) begin
      if (cyc_reg <= i_waits)
        o_execute_handshake = `HS_WAIT;
      else if (cyc_reg == i_waits + 4'h1)
        o_execute_handshake = i_fin;
      else if (i_fin == `HS_GO && cyc_reg == i_waits + 4'h2)
        o_execute_handshake = `HS_LAST;
    end
  end
  // read words follow each c-cycle like a load; otherwise the bus churns
  always @(posedge i_core_clk) begin
    if (i_fetched_word_valid && i_ready) begin
      busy_reg <= i_dec != `HS_ABSENT;
      cyc_reg <= 4'h1;
      word2_reg <= 1'b0;
    end else begin
      busy_reg <= busy_reg && !i_ready;
      cyc_reg <= cyc_reg + 4'h1;
    end
    if (i_data_cycle == `CYC_C) begin
      o_read_data <= word2_reg ? i_word2 : i_word1;
      word2_reg <= 1'b1;
    end else
      o_read_data <= ~o_read_data;
  end
endmodule // cp_model

// [test/cp_transfer_seq_tb.sv]
/* bench for the transfer sequencer against the coprocessor model.
   assumes inputs may change 1 ns after each rising edge. */
`include "cp_xfer_defs.vh"
module cp_transfer_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk, i_reset_n, i_fetched_word_valid, i_cond_pass, i_compressed_state, i_irq_pending;
  logic [1:0] i_fetched_word_kind, i_decode_handshake, i_execute_handshake, p_dec, p_fin;
  logic [3:0] p_waits;
  logic [31:0] i_fetch_pc, i_src_data, i_second_source_reg, i_read_data, p_w1, p_w2;
  logic o_ready, o_undef_trap, o_abandoned, o_fetched_word_request_n, o_fetched_word_sequential;
  logic o_data_request_n, o_data_sequential, o_data_address_oe, o_write_data_oe;
  logic o_read_done, o_pass, o_late_cancel_flag;
  logic [31:0] o_fetch_address, o_data_address_bus, o_write_data, o_read_word1, o_read_word2;
  int err_total = 0;
  int total_checks = 0;
  cp_transfer_seq u_cp_transfer_seq (.*);
  cp_model u_cp_model (.i_core_clk(i_core_clk), .i_fetched_word_valid(i_fetched_word_valid),
    .i_ready(o_ready), .i_data_cycle({o_data_request_n, o_data_sequential}),
    .i_dec(p_dec), .i_waits(p_waits), .i_fin(p_fin), .i_word1(p_w1), .i_word2(p_w2),
    .o_decode_handshake(i_decode_handshake), .o_execute_handshake(i_execute_handshake),
    .o_read_data(i_read_data));
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  ////////////////////////////////////////
  task tick;
    @(posedge i_core_clk);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // instruction and data cycle types plus pass, as one word
  task cyc(input logic [1:0] ei, input logic [1:0] ed, input logic ep);
    chk({o_fetched_word_request_n, o_fetched_word_sequential, o_data_request_n, o_data_sequential, o_pass},
      {ei, ed, ep});
  endtask
  task summarize;
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task ready_wait;
    int n;
    n = 0;
    while (o_ready !== 1'b1) begin
      tick;
      n++;
      if (n > 40) begin
        err_total++;
        summarize;
      end
    end
  endtask
  // offer one instruction with a coprocessor script, return in cycle 1
  task issue(input logic [1:0] k, input logic c, input logic z, input logic [1:0] d,
      input logic [3:0] w, input logic [1:0] f);
    ready_wait;
    p_dec = d;
    p_waits = w;
    p_fin = f;
    i_fetched_word_kind = k;
    i_cond_pass = c;
    i_compressed_state = z;
    i_fetched_word_valid = 1'b1;
    tick;
    i_fetched_word_valid = 1'b0;
  endtask
  ////////////////////////////////////////
  task s_skip;
    i_fetch_pc = 32'h100;
    issue(`KIND_TO_CP, 1'b0, 1'b0, `HS_LAST, 4'h0, `HS_ABSENT);
    cyc(`CYC_S, `CYC_I, 1'b0);
    chk(o_fetch_address, 32'h100);
    chk(o_ready, 32'h1);
  endtask
  task s_move_out;
    i_fetch_pc = 32'h200;
    i_src_data = 32'hA5A5_0F0F;
    issue(`KIND_TO_CP, 1'b1, 1'b0, `HS_LAST, 4'h0, `HS_ABSENT);
    cyc(`CYC_S, `CYC_C, 1'b1);
    tick;
    chk(o_write_data, 32'hA5A5_0F0F);
    chk(o_write_data_oe, 32'h1);
  endtask
  task s_move_wait;
    i_fetch_pc = 32'h300;
    i_src_data = 32'h1234_5678;
    issue(`KIND_TO_CP, 1'b1, 1'b0, `HS_WAIT, 4'h2, `HS_LAST);
    for (int i = 0; i < 3; i++) begin
      cyc(`CYC_I, `CYC_I, 1'b1);
      chk(o_fetch_address, 32'h300);
      tick;
    end
    cyc(`CYC_S, `CYC_C, 1'b1);
    tick;
    chk(o_write_data, 32'h1234_5678);
  endtask
  task s_dbl_in;
    p_w1 = 32'hCAFE_0001;
    p_w2 = 32'h0BAD_0002;
    issue(`KIND_DBL_FROM_CP, 1'b1, 1'b0, `HS_GO, 4'h0, `HS_LAST);
    cyc(`CYC_I, `CYC_C, 1'b1);
    tick;
    cyc(`CYC_S, `CYC_C, 1'b1);
    tick;
    tick;
    chk(o_read_done, 32'h1);
    chk(o_read_word1, 32'hCAFE_0001);
    chk(o_read_word2, 32'h0BAD_0002);
  endtask
  // single move in, decode last: one c-cycle, word captured like a load
  task s_move_in;
    p_w1 = 32'h5A5A_C3C3;
    issue(`KIND_FROM_CP, 1'b1, 1'b0, `HS_LAST, 4'h0, `HS_ABSENT);
    cyc(`CYC_S, `CYC_C, 1'b1);
    tick;
    chk(o_write_data_oe, 32'h0);
    tick;
    chk(o_read_done, 32'h1);
    chk(o_read_word1, 32'h5A5A_C3C3);
  endtask
  task s_dbl_out;
    i_src_data = 32'h1111_AAAA;
    i_second_source_reg = 32'h2222_BBBB;
    issue(`KIND_DBL_TO_CP, 1'b1, 1'b0, `HS_WAIT, 4'h1, `HS_GO);
    repeat (2) begin
      cyc(`CYC_I, `CYC_I, 1'b1);
      tick;
    end
    cyc(`CYC_I, `CYC_C, 1'b1);
    tick;
    cyc(`CYC_S, `CYC_C, 1'b1);
    chk(o_write_data, 32'h1111_AAAA);
    tick;
    chk(o_write_data, 32'h2222_BBBB);
  endtask
  task s_absent;
    issue(`KIND_TO_CP, 1'b1, 1'b0, `HS_ABSENT, 4'h0, `HS_ABSENT);
    cyc(`CYC_I, `CYC_I, 1'b1);
    tick;
    chk(o_undef_trap, 32'h1);
    for (int i = 0; i < 3; i++) begin
      chk(o_fetch_address, 32'h4 + 32'h4 * i);
      cyc((i == 0) ? `CYC_N : `CYC_S, `CYC_I, 1'b0);
      if (i < 2)
        tick;
    end
  endtask
  task s_wait_absent;
    issue(`KIND_DBL_TO_CP, 1'b1, 1'b0, `HS_WAIT, 4'h1, `HS_ABSENT);
    repeat (2) begin
      cyc(`CYC_I, `CYC_I, 1'b1);
      tick;
    end
    chk(o_fetch_address, `TRAP_FIRST_ADDR);
    cyc(`CYC_N, `CYC_I, 1'b0);
  endtask
  task s_irq;
    issue(`KIND_FROM_CP, 1'b1, 1'b0, `HS_WAIT, 4'h8, `HS_LAST);
    i_irq_pending = 1'b1;
    tick;
    i_irq_pending = 1'b0;
    chk(o_abandoned, 32'h1);
    cyc(`CYC_I, `CYC_I, 1'b0);
  endtask
  task s_compressed;
    issue(`KIND_FROM_CP, 1'b1, 1'b1, `HS_LAST, 4'h0, `HS_ABSENT);
    chk(o_fetch_address, `TRAP_FIRST_ADDR);
    chk(o_undef_trap, 32'h1);
  endtask
  ////////////////////////////////////////
  initial begin
    {i_reset_n, i_fetched_word_valid, i_fetched_word_kind, i_cond_pass, i_compressed_state} = '0;
    {i_fetch_pc, i_irq_pending, i_src_data, i_second_source_reg} = '0;
    {p_dec, p_waits, p_fin, p_w1, p_w2} = '0;
    repeat (20) @(posedge i_core_clk);
    #1;
    cyc(`CYC_I, `CYC_I, 1'b0);
    chk(o_fetch_address, 32'h0);
    i_reset_n = 1'b1;
    s_skip;
    s_move_out;
    s_move_wait;
    s_dbl_in;
    s_move_in;
    s_dbl_out;
    s_absent;
    s_wait_absent;
    s_irq;
    s_compressed;
    ready_wait;
    summarize;
  end
endmodule // cp_transfer_seq_tb
bind cp_transfer_seq cp_transfer_props u_cp_transfer_props (.*);
